// >>> rtl/tbt_pkg.sv
// Shared constants for the touch baseline tracker
package tbt_pkg;

  // ----------------------------------------------------------------
  // Sizing
  // ----------------------------------------------------------------
  localparam int NUM_SENS = 4;
  localparam int NUM_ROWS = 2;
  localparam int NUM_COLS = 2;
  localparam int SCAN_RES = 10;
  localparam logic [SCAN_RES-1:0] SCAN_CYC = 10'h3FF;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NOISE = 8'h04;
  localparam logic [7:0] REG_FINGER = 8'h08;
  localparam logic [7:0] REG_DEBLIM = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_STATE = 8'h18;
  localparam logic [7:0] REG_SENS0 = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SCAN_EN = 0;
  localparam int CTRL_AUTO_RST = 1;
  localparam int HI_FIELD = 16;
  localparam int STATE_ISECT = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [SCAN_RES-1:0] NOISE_RST = 10'h014;
  localparam logic [SCAN_RES-1:0] NNOISE_RST = 10'h014;
  localparam logic [SCAN_RES-1:0] FINGER_RST = 10'h064;
  localparam logic [CNT_W-1:0] HYS_RST = 8'h0A;
  localparam logic [CNT_W-1:0] DEB_RST = 8'h03;
  localparam logic [CNT_W-1:0] LBR_RST = 8'h1E;

endpackage

// >>> rtl/tbt_scan_ctr.sv
// Modulator bit counter producing one raw count per sensor scan
`timescale 1ns/10ps
module tbt_scan_ctr
  import tbt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic mod_bit_i,
  output logic [1:0] sel_o,
  output logic [SCAN_RES-1:0] raw_o,
  output logic vld_o
);

  typedef struct packed {
    logic [SCAN_RES-1:0] cnt;
    logic [SCAN_RES-1:0] acc;
    logic [1:0] sel;
    logic [SCAN_RES-1:0] raw;
    logic vld;
  } tbt_ctr_t;

  tbt_ctr_t q_r;
  tbt_ctr_t q_nxt;

  // ----------------------------------------------------------------
  // Scan counting
  // ----------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.vld = 1'b0;
    if (en_i)
    begin
      // (RULE_07) clk_i is the modulator clock
      // (RULE_08) scan ends after SCAN_CYC periods
      if (q_r.cnt == SCAN_CYC - 10'h001)
      begin
        // (RULE_09) raw count is SCAN_RES wide
        q_nxt.raw = q_r.acc + {{(SCAN_RES-1){1'b0}}, mod_bit_i};
        q_nxt.vld = 1'b1;
        q_nxt.cnt = '0;
        q_nxt.acc = '0;
        q_nxt.sel = q_r.sel + 2'h1;
      end
      else
      begin
        q_nxt.cnt = q_r.cnt + 10'h001;
        q_nxt.acc = q_r.acc + {{(SCAN_RES-1){1'b0}}, mod_bit_i};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  // Sensor index moves on with the pulse, so report the finished one
  assign sel_o = q_r.sel - 2'h1;
  assign raw_o = q_r.raw;
  assign vld_o = q_r.vld;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  scan_length_a: assert property (vld_o |-> $past(q_r.cnt) == SCAN_CYC - 10'h001) // RULE_08
    else $error("scan did not last the full period");
  pulse_gap_a: assert property (vld_o |=> !vld_o [*8]) // RULE_07
    else $error("raw counts came too close together");

endmodule

// >>> rtl/tbt_tracker.sv
// Baseline tracking, touch decision and register file of the touch tracker
// Contract
// (RULE_01) Count consecutive samples with raw below baseline beyond negative noise threshold.
// (RULE_02) When that count exceeds the limit, load baseline with current raw count.
// (RULE_03) Track baseline only while baseline minus raw stays below negative threshold.
// (RULE_04) Raw above baseline by more than noise threshold is a likely signal.
// (RULE_05) Auto reset on: baseline updates every scan, even with a signal.
// (RULE_06) Auto reset off: baseline updates only when difference below noise threshold.
// (RULE_07) Raw counter runs on the modulator clock sampling the modulator bit.
// (RULE_08) A scan lasts two to the resolution minus one modulator periods.
// (RULE_09) Raw count width equals the scan resolution.
// (RULE_10) A matrix of M rows and N columns gives M times N intersections.
// (RULE_11) The matrix reports at most one touched intersection at a time.
// (RULE_12) Difference is raw minus baseline, zero if negative or below noise.
// (RULE_13) On above finger threshold plus hysteresis, off below threshold minus hysteresis.
// (RULE_14) Touch reported only after on condition holds for debounce samples.
// (RULE_15) After reset baseline takes first raw count; counters and state cleared.
// (RULE_16) Thresholds, hysteresis, debounce, limit and auto reset are static settings.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
module tbt_tracker
  import tbt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mod_bit_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [NUM_SENS-1:0] touch_o,
  output logic [NUM_ROWS*NUM_COLS-1:0] isect_o,
  output logic irq_o
);

  typedef struct packed {
    logic [NUM_SENS-1:0][SCAN_RES-1:0] bl;
    logic [NUM_SENS-1:0][SCAN_RES-1:0] diff;
    logic [NUM_SENS-1:0][CNT_W-1:0] low;
    logic [NUM_SENS-1:0][CNT_W-1:0] deb;
    logic [NUM_SENS-1:0] on;
    logic [NUM_SENS-1:0] init;
    logic [NUM_ROWS*NUM_COLS-1:0] isect;
    logic [1:0] ctrl;
    logic [SCAN_RES-1:0] noise;
    logic [SCAN_RES-1:0] nnoise;
    logic [SCAN_RES-1:0] finger;
    logic [CNT_W-1:0] hys;
    logic [CNT_W-1:0] debc;
    logic [CNT_W-1:0] lbr;
    logic [2*NUM_SENS-1:0] stat;
    logic [2*NUM_SENS-1:0] mask;
    logic ack;
    logic [31:0] dat;
  } tbt_state_t;

  tbt_state_t q_r;
  tbt_state_t q_nxt;

  logic [1:0] sel;
  logic [SCAN_RES-1:0] raw;
  logic raw_vld;

  tbt_scan_ctr u_scan (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(q_r.ctrl[CTRL_SCAN_EN]),
    .mod_bit_i(mod_bit_i),
    .sel_o(sel),
    .raw_o(raw),
    .vld_o(raw_vld)
  );

  // ----------------------------------------------------------------
  // Per-sample analysis of the sensor just scanned
  // ----------------------------------------------------------------
  logic [SCAN_RES-1:0] cur_bl;
  logic [SCAN_RES-1:0] pdiff;
  logic [SCAN_RES-1:0] ndiff;
  logic pos;
  logic neg;
  logic neg_hit;
  logic signal;
  logic upd_ok;
  logic low_reset;
  logic [CNT_W-1:0] low_inc;
  logic [SCAN_RES-1:0] diff_val;
  logic [SCAN_RES:0] on_thr;
  logic [SCAN_RES:0] off_thr;
  logic [CNT_W-1:0] deb_inc;
  logic deb_done;

  always_comb
  begin
    cur_bl = q_r.bl[sel];
    pos = raw > cur_bl;
    neg = cur_bl > raw;
    pdiff = pos ? raw - cur_bl : '0;
    ndiff = neg ? cur_bl - raw : '0;
    // (RULE_01) abnormally low sample
    neg_hit = neg && (ndiff > q_r.nnoise);
    low_inc = (q_r.low[sel] == 8'hFF) ? q_r.low[sel] : q_r.low[sel] + 8'h01;
    // (RULE_02) limit exceeded
    low_reset = neg_hit && (low_inc > q_r.lbr);
    // (RULE_04) likely valid signal versus noise
    signal = pos && (pdiff > q_r.noise);
    // (RULE_03) (RULE_05) (RULE_06) when tracking is allowed
    // A raw count above the baseline is never a negative excursion, even with a zero threshold
    upd_ok = (!neg || (ndiff < q_r.nnoise)) &&
             (q_r.ctrl[CTRL_AUTO_RST] || !pos || (pdiff < q_r.noise));
    // (RULE_12) difference clamped to zero
    diff_val = (pos && (pdiff >= q_r.noise)) ? pdiff : '0;
    on_thr = {1'b0, q_r.finger} + {3'h0, q_r.hys};
    off_thr = (q_r.finger > {2'h0, q_r.hys}) ? {1'b0, q_r.finger - {2'h0, q_r.hys}} : '0;
    deb_inc = (q_r.deb[sel] == 8'hFF) ? q_r.deb[sel] : q_r.deb[sel] + 8'h01;
    // Zero debounce setting acts as one sample
    deb_done = (deb_inc >= q_r.debc);
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic [1:0] rd_idx;

  always_comb
  begin
    rd_data = '0;
    rd_idx = wb_adr_i[3:2];
    unique case (wb_adr_i)
      REG_CTRL: rd_data[1:0] = q_r.ctrl;
      REG_NOISE:
      begin
        rd_data[SCAN_RES-1:0] = q_r.noise;
        rd_data[HI_FIELD +: SCAN_RES] = q_r.nnoise;
      end
      REG_FINGER:
      begin
        rd_data[SCAN_RES-1:0] = q_r.finger;
        rd_data[HI_FIELD +: CNT_W] = q_r.hys;
      end
      REG_DEBLIM:
      begin
        rd_data[CNT_W-1:0] = q_r.debc;
        rd_data[HI_FIELD +: CNT_W] = q_r.lbr;
      end
      REG_STATUS: rd_data[2*NUM_SENS-1:0] = q_r.stat;
      REG_MASK: rd_data[2*NUM_SENS-1:0] = q_r.mask;
      REG_STATE:
      begin
        rd_data[NUM_SENS-1:0] = q_r.on;
        rd_data[STATE_ISECT +: NUM_ROWS*NUM_COLS] = q_r.isect;
      end
      REG_SENS0, REG_SENS0 + 8'h04, REG_SENS0 + 8'h08, REG_SENS0 + 8'h0C:
      begin
        rd_data[SCAN_RES-1:0] = q_r.bl[rd_idx];
        rd_data[HI_FIELD +: SCAN_RES] = q_r.diff[rd_idx];
      end
      default: rd_data = '0;
    endcase
  end

  // Byte-lane merge of a write into a 32-bit word
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Matrix intersection pick
  // ----------------------------------------------------------------
  logic [NUM_ROWS*NUM_COLS-1:0] isect_val;

  // (RULE_10) rows are sensors 0..M-1, columns M..M+N-1
  always_comb
  begin
    isect_val = '0;
    // (RULE_11) only the lowest row and column pair wins
    for (int r = NUM_ROWS - 1; r >= 0; r--)
    begin
      for (int c = NUM_COLS - 1; c >= 0; c--)
      begin
        if (q_r.on[r] && q_r.on[NUM_ROWS + c])
        begin
          isect_val = '0;
          isect_val[r*NUM_COLS + c] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic [31:0] w32;

  always_comb
  begin
    q_nxt = q_r;
    wr_go = q_r.ack && wb_cyc_i && wb_stb_i && wb_we_i;
    rd_go = q_r.ack && wb_cyc_i && wb_stb_i && !wb_we_i;
    w32 = wr_merge(rd_data, wb_dat_i, wb_sel_i);
    q_nxt.ack = wb_cyc_i && wb_stb_i && !q_r.ack;
    q_nxt.dat = rd_data;
    q_nxt.isect = isect_val;

    // Writes land on the edge that the master samples ack
    // (RULE_16) settings held static until software rewrites them
    if (wr_go)
    begin
      unique case (wb_adr_i)
        REG_CTRL: q_nxt.ctrl = w32[1:0];
        REG_NOISE:
        begin
          q_nxt.noise = w32[SCAN_RES-1:0];
          q_nxt.nnoise = w32[HI_FIELD +: SCAN_RES];
        end
        REG_FINGER:
        begin
          q_nxt.finger = w32[SCAN_RES-1:0];
          q_nxt.hys = w32[HI_FIELD +: CNT_W];
        end
        REG_DEBLIM:
        begin
          q_nxt.debc = w32[CNT_W-1:0];
          q_nxt.lbr = w32[HI_FIELD +: CNT_W];
        end
        REG_MASK: q_nxt.mask = w32[2*NUM_SENS-1:0];
        default: q_nxt.ctrl = q_r.ctrl;
      endcase
    end
    // Read clears status; set below wins over this clear
    if (rd_go && (wb_adr_i == REG_STATUS))
      q_nxt.stat = '0;

    if (raw_vld)
    begin
      if (!q_r.init[sel])
      begin
        // (RULE_15) first raw count seeds the baseline
        q_nxt.init[sel] = 1'b1;
        q_nxt.bl[sel] = raw;
        q_nxt.low[sel] = '0;
        q_nxt.deb[sel] = '0;
        q_nxt.diff[sel] = '0;
      end
      else
      begin
        // (RULE_01) consecutive low-sample count
        q_nxt.low[sel] = neg_hit ? low_inc : '0;
        if (low_reset)
        begin
          // (RULE_02) baseline reloaded from raw
          q_nxt.bl[sel] = raw;
          q_nxt.low[sel] = '0;
        end
        else if (upd_ok && pos)
          q_nxt.bl[sel] = cur_bl + 10'h001;
        else if (upd_ok && neg)
          q_nxt.bl[sel] = cur_bl - 10'h001;
        q_nxt.diff[sel] = diff_val;

        // (RULE_13) (RULE_14) hysteresis and debounce
        if ({1'b0, diff_val} > on_thr)
        begin
          q_nxt.deb[sel] = deb_inc;
          if (deb_done && !q_r.on[sel])
          begin
            q_nxt.on[sel] = 1'b1;
            q_nxt.stat[sel] = 1'b1;
          end
        end
        else
        begin
          q_nxt.deb[sel] = '0;
          if (({1'b0, diff_val} < off_thr) && q_r.on[sel])
          begin
            q_nxt.on[sel] = 1'b0;
            q_nxt.stat[NUM_SENS + sel] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= '0;
      q_r.ctrl <= CTRL_RST;
      q_r.noise <= NOISE_RST;
      q_r.nnoise <= NNOISE_RST;
      q_r.finger <= FINGER_RST;
      q_r.hys <= HYS_RST;
      q_r.debc <= DEB_RST;
      q_r.lbr <= LBR_RST;
    end
    else
      q_r <= q_nxt;
  end

  assign wb_ack_o = q_r.ack;
  assign wb_dat_o = q_r.dat;
  assign touch_o = q_r.on;
  assign isect_o = q_r.isect;
  assign irq_o = |(q_r.stat & q_r.mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  low_reload_a: assert property (raw_vld && q_r.init[sel] && low_reset |=> // RULE_02
      q_r.bl[$past(sel)] == $past(raw) && q_r.low[$past(sel)] == 8'h00)
    else $error("baseline not reloaded after low limit");
  low_count_a: assert property (raw_vld && q_r.init[sel] && neg_hit && !low_reset |=> // RULE_01
      q_r.low[$past(sel)] == $past(low_inc))
    else $error("low sample count did not advance");
  track_hold_a: assert property (raw_vld && q_r.init[sel] && !low_reset && // RULE_03
      ndiff >= q_r.nnoise && neg |=> q_r.bl[$past(sel)] == $past(cur_bl))
    else $error("baseline moved during a negative excursion");
  no_auto_a: assert property (raw_vld && q_r.init[sel] && !q_r.ctrl[CTRL_AUTO_RST] && // RULE_06
      signal |=> q_r.bl[$past(sel)] == $past(cur_bl))
    else $error("baseline moved on a signal without auto reset");
  auto_move_a: assert property (raw_vld && q_r.init[sel] && q_r.ctrl[CTRL_AUTO_RST] && // RULE_05
      signal |=> q_r.bl[$past(sel)] == $past(cur_bl) + 10'h001)
    else $error("auto reset did not track a signal");
  diff_clamp_a: assert property (raw_vld && q_r.init[sel] |=> // RULE_12
      q_r.diff[$past(sel)] == 10'h000 || q_r.diff[$past(sel)] >= $past(q_r.noise))
    else $error("difference below noise not forced to zero");
  debounce_on_a: assert property (raw_vld && !q_r.on[sel] && q_nxt.on[sel] |-> // RULE_14
      deb_inc >= q_r.debc && {1'b0, diff_val} > on_thr)
    else $error("touch reported before debounce");
  one_isect_a: assert property ($onehot0(isect_o)) // RULE_11
    else $error("more than one intersection reported");
  first_seed_a: assert property (raw_vld && !q_r.init[sel] |=> // RULE_15
      q_r.bl[$past(sel)] == $past(raw) && !q_r.on[$past(sel)])
    else $error("baseline not seeded from first raw count");
  status_clear_a: assert property (rd_go && wb_adr_i == REG_STATUS && !raw_vld |=> !irq_o)
    else $error("status read did not clear the interrupt");

  touch_cov_c: cover property ($rose(touch_o[0]));
  release_cov_c: cover property ($fell(touch_o[0]));
  low_rst_cov_c: cover property (raw_vld && low_reset);
  isect_cov_c: cover property (isect_o != 4'h0);

endmodule

// >>> tb/tbt_front_model.sv
// Behavioural sensing front end that emits modulator bits per sensor scan
`timescale 1ns/10ps
module tbt_front_model
  import tbt_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NUM_SENS*SCAN_RES-1:0] tgt_i,
  output logic mod_bit_o,
  output logic [1:0] sens_o,
  output logic [SCAN_RES-1:0] pos_o
);
  logic [SCAN_RES-1:0] ones_r;

  // ----------------------------------------------------------------
  // Scan window
  // ----------------------------------------------------------------
  // one window per sensor
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_o <= '0;
      sens_o <= '0;
      ones_r <= '0;
    end
    else
    begin
      if (pos_o == SCAN_CYC - 10'h001)
      begin
        pos_o <= '0;
        sens_o <= sens_o + 2'h1;
      end
      else
      begin
        pos_o <= pos_o + 10'h001;
      end
      if (pos_o == 10'h001)
      begin
        ones_r <= tgt_i[sens_o*SCAN_RES +: SCAN_RES];
      end
    end
  end

  // Ones kept off the window edges so a one-cycle skew keeps the count
  // one bit per clock
  assign mod_bit_o = (pos_o >= 10'h002) && (pos_o <= ones_r + 10'h001);
endmodule

// >>> tb/tb_tbt_tracker.sv
// Self-checking bench for the touch baseline tracker
`timescale 1ns/10ps
module tb_tbt_tracker;
  import tbt_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, mod_bit;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, v;
  logic [3:0] wb_sel_i, touch_o, isect_o;
  logic irq_o, wb_ack_o;
  logic [NUM_SENS*SCAN_RES-1:0] tgt;
  logic [1:0] sens;
  logic [SCAN_RES-1:0] pos;
  int num_errors, check_count, base, i;
  logic [31:0] seed;

  tbt_tracker u_dut (.clk_i(clk_i), .rst_i(rst_i), .mod_bit_i(mod_bit), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .touch_o(touch_o),
    .isect_o(isect_o), .irq_o(irq_o));
  tbt_front_model u_fe (.clk_i(clk_i), .rst_i(rst_i), .tgt_i(tgt), .mod_bit_o(mod_bit),
    .sens_o(sens), .pos_o(pos));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; no fixed latency assumed
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    // Only the watchdog ends a missing answer
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    wb(1'b0, adr, 32'h0, r);
    chk(nm, exp, r);
  endtask

  // Next start of sensor 0 window, then settle past the last update
  task automatic next_pass(input int a, input int b, input int c, input int d);
    do
    begin
      @(posedge clk_i);
    end
    while (!(sens === 2'h0 && pos === 10'h000));
    tgt <= {d[9:0], c[9:0], b[9:0], a[9:0]};
    repeat (10) @(posedge clk_i);
  endtask

  function automatic logic [31:0] sx(input int bl, input int df);
    return {6'h00, df[9:0], 6'h00, bl[9:0]};
  endfunction

  function automatic logic [7:0] sa(input int k);
    return REG_SENS0 + 8'(4 * k);
  endfunction

  initial
  begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    check_count = 0;
    seed = 32'hB494F535;
    base = 300 + ($unsigned($random(seed)) % 300);
    tgt = {4{base[9:0]}};
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("outputs", 32'h0, {23'h0, touch_o, isect_o, irq_o});
    rd_chk(REG_CTRL, 32'h1, "ctrl");
    rd_chk(REG_NOISE, 32'h0014_0014, "noise");
    rd_chk(REG_FINGER, 32'h000A_0064, "finger");
    rd_chk(REG_DEBLIM, 32'h001E_0003, "deblim");
    wb(1'b1, 8'h40, $random(seed), v);
    rd_chk(8'h40, 32'h0, "unmapped");
    wb(1'b1, REG_MASK, 32'h1, v);
    wb(1'b1, REG_DEBLIM, 32'h0002_0003, v);
    rd_chk(REG_MASK, 32'h1, "mask");
    // Sensor 0,3 touched; 1 noise only; 2 pulled abnormally low
    next_pass(base + 200, base + 10, base - 100, base + 200);
    for (i = 0; i < 4; i++)
      rd_chk(sa(i), sx(base, 0), "seed");
    next_pass(base + 200, base + 10, base - 100, base + 200);
    chk("touch_o", 32'h0, {28'h0, touch_o});
    rd_chk(sa(0), sx(base, 200), "sens0");
    rd_chk(sa(1), sx(base + 1, 0), "sens1");
    rd_chk(sa(2), sx(base, 0), "sens2");
    next_pass(base + 200, base + 10, base - 100, base + 200);
    chk("touch_o", 32'h0, {28'h0, touch_o});
    rd_chk(sa(2), sx(base, 0), "sens2");
    next_pass(base + 200, base + 10, base - 100, base + 200);
    wb(1'b1, REG_CTRL, 32'h3, v);
    chk("touch_o", 32'h9, {28'h0, touch_o});
    chk("isect_o", 32'h2, {28'h0, isect_o});
    chk("irq_o", 32'h1, {31'h0, irq_o});
    rd_chk(sa(2), sx(base - 100, 0), "sens2");
    rd_chk(REG_STATE, 32'h0000_0209, "state");
    rd_chk(REG_STATUS, 32'h0000_0009, "status");
    rd_chk(REG_STATUS, 32'h0, "status");
    chk("irq_o", 32'h0, {31'h0, irq_o});
    next_pass(base, base, base, base);
    wb(1'b1, REG_CTRL, 32'h1, v);
    wb(1'b0, sa(0), 32'h0, v);
    chk("base0", 32'(base + 1), {22'h0, v[9:0]});
    wb(1'b0, sa(3), 32'h0, v);
    chk("base3", 32'(base + 1), {22'h0, v[9:0]});
    chk("touch_o", 32'h9, {28'h0, touch_o});
    next_pass(base, base, base, base);
    chk("touch_o", 32'h0, {24'h0, touch_o, isect_o});
    rd_chk(REG_STATUS, 32'h0000_0090, "status");
    wb(1'b0, sa(0), 32'h0, v);
    chk("base0", 32'(base), {22'h0, v[9:0]});
    end_sim();
  end
endmodule
